/* logic/pad_mux_pkg.sv */
// package: constants and types for the pad function and pull control block
package pad_mux_pkg;

  // pad indices for the per-pad pull controls
  localparam int unsigned PAD_COUNT = 10;
  localparam int unsigned PAD_HOST_DOUT = 0;
  localparam int unsigned PAD_SEC_DIN = 1;
  localparam int unsigned PAD_SEC_CLOCK = 2;
  localparam int unsigned PAD_FIRST_IRQ = 3;
  localparam int unsigned PAD_RESERVED = 4;
  localparam int unsigned PAD_SECOND_IRQ = 5;
  localparam int unsigned PAD_SEC_SELECT = 6;
  localparam int unsigned PAD_SEC_DOUT = 7;
  localparam int unsigned PAD_HOST_SELECT = 8;
  localparam int unsigned PAD_HOST_CLOCK = 9;

  // field position of the enable and direction bits in each pad control
  localparam int unsigned PULL_BIT = 0;

  // pull direction encodings
  localparam logic PULL_DOWN = 1'b0;
  localparam logic PULL_UP = 1'b1;

  // reset defaults: all pulls on and up except the first interrupt pad
  localparam logic [9:0] PULL_EN_RESET = 10'h3f7;
  localparam logic [9:0] PULL_DIR_RESET = 10'h3ff;

  // slave address: six fixed upper bits, low bit from the address-select pad
  localparam logic [5:0] SLAVE_ADDR_UPPER = 6'h34;

  typedef enum logic [1:0] {
    SCEN_SINGLE = 2'b00,
    SCEN_STAB_SPI = 2'b01,
    SCEN_I2C_MASTER = 2'b10
  } scenario_t;

  typedef enum logic [1:0] {
    HOST_I2C = 2'b00,
    HOST_I3C = 2'b01,
    HOST_SPI3 = 2'b10,
    HOST_SPI4 = 2'b11
  } host_proto_t;

  typedef enum logic [1:0] {
    IRQ2_OUT = 2'b00,
    IRQ2_FRAME_SYNC_IN = 2'b01,
    IRQ2_EXTERNAL_CLOCK_IN = 2'b10
  } irq2_role_t;

  // secondary port default after reset: enabled, three-wire serial
  localparam scenario_t SCEN_RESET = SCEN_STAB_SPI;
  localparam logic SEC_THREE_WIRE_RESET = 1'b1;

endpackage : pad_mux_pkg

/* logic/pad_pull_if.sv */
// interface: pull controls passed between the mux and the pull register module
interface pad_pull_if #(parameter int unsigned N = 10);
  logic [N-1:0] wr_en;
  logic [N-1:0] wr_dir;
  logic [N-1:0] wr_data_en;
  logic [N-1:0] wr_data_dir;
  logic [N-1:0] pull_en;
  logic [N-1:0] pull_dir;
  modport owner (input wr_en, input wr_dir, input wr_data_en, input wr_data_dir,
                 output pull_en, output pull_dir);
  modport user (output wr_en, output wr_dir, output wr_data_en, output wr_data_dir,
                input pull_en, input pull_dir);
endinterface : pad_pull_if

/* logic/pad_pull_regs.sv */
// module: per-pad pull enable and pull direction flip-flops
module pad_pull_regs
  import pad_mux_pkg::*;
#(
  parameter int unsigned N = PAD_COUNT,
  parameter logic [N-1:0] EN_RESET = PULL_EN_RESET,
  parameter logic [N-1:0] DIR_RESET = PULL_DIR_RESET
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pull control bundle
  pad_pull_if.owner pulls
);

  logic [N-1:0] pull_en;
  logic [N-1:0] pull_dir;

  // each bit is written independently when its strobe is high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pull_en <= EN_RESET;
      pull_dir <= DIR_RESET;
    end else begin
      pull_en <= (pulls.wr_data_en & pulls.wr_en) | (pull_en & ~pulls.wr_en);
      pull_dir <= (pulls.wr_data_dir & pulls.wr_dir) | (pull_dir & ~pulls.wr_dir);
    end
  end

  assign pulls.pull_en = pull_en;
  assign pulls.pull_dir = pull_dir;

endmodule : pad_pull_regs

/* logic/pad_function_and_pull_control.sv */
// module: pad function multiplexing and pull control for the serial pins
// Summary of operation
// - pull-enable bit: 0 off, 1 on
// - pull-direction bit: 0 down, 1 up
// - reset: pulls enabled and up, except first interrupt
// - reset: first interrupt pad pull disabled
// - host data-out pad: SPI output or address bit
// - host clock and data pads follow host protocol
// - secondary data pad role follows scenario
// - secondary clock pad: SPI slave or I2C master
// - secondary select used only in stabilisation scenario
// - secondary data-out drives only in stabilisation scenario
// - first interrupt push-pull or open-drain
// - combined mode merges all interrupts onto first
// - second interrupt pad: output, frame sync, clock
// - second interrupt carries secondary interrupt when enabled
// - slave address 1101000 or 1101001 by select pad
// - secondary enabled, three-wire by default; override kept apart
module pad_function_and_pull_control
  import pad_mux_pkg::*;
#(
  parameter int unsigned N = PAD_COUNT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pull control writes from the host register path
  input wire logic [N-1:0] pull_en_write,
  input wire logic [N-1:0] pull_dir_write,
  input wire logic [N-1:0] pull_en_value,
  input wire logic [N-1:0] pull_dir_value,
  // secondary port override written by the host
  input wire logic override_write,
  input wire logic [1:0] override_scenario,
  input wire logic override_three_wire,
  // host protocol and interrupt configuration
  input wire logic [1:0] host_protocol,
  input wire logic first_irq_open_drain,
  input wire logic second_irq_open_drain,
  input wire logic irq_combined,
  input wire logic [1:0] second_irq_role,
  // internal function side
  input wire logic host_spi_out_data,
  input wire logic host_spi_out_en,
  input wire logic host_sda_low,
  input wire logic host_three_wire_out,
  input wire logic host_three_wire_oe,
  input wire logic secondary_spi_out_data,
  input wire logic secondary_spi_out_en,
  input wire logic secondary_three_wire_out,
  input wire logic secondary_three_wire_oe,
  input wire logic i2c_master_data_low,
  input wire logic i2c_master_clock_low,
  input wire logic host_irq1,
  input wire logic host_irq2,
  input wire logic secondary_irq,
  // pad inputs
  input wire logic host_serial_out_in,
  input wire logic host_bus_clock_in,
  input wire logic host_bus_data_in,
  input wire logic host_chip_select_in,
  input wire logic secondary_data_in,
  input wire logic secondary_clock_in,
  input wire logic secondary_chip_select_in,
  input wire logic second_irq_pad_in,
  // pad outputs and enables
  output logic host_serial_out,
  output logic host_serial_out_oe,
  output logic host_bus_data_out,
  output logic host_bus_data_oe,
  output logic secondary_data_out,
  output logic secondary_data_oe,
  output logic secondary_clock_out,
  output logic secondary_clock_oe,
  output logic secondary_serial_out,
  output logic secondary_serial_out_oe,
  output logic first_irq_out,
  output logic first_irq_oe,
  output logic second_irq_out,
  output logic second_irq_oe,
  // recovered inputs to the internal function side
  output logic [6:0] slave_address,
  output logic host_clock_to_core,
  output logic host_data_to_core,
  output logic host_select_to_core,
  output logic secondary_data_to_core,
  output logic secondary_clock_to_core,
  output logic secondary_select_to_core,
  output logic frame_sync_in,
  output logic external_clock_in,
  // pad pull controls and status
  output logic [N-1:0] pull_en,
  output logic [N-1:0] pull_dir,
  output logic [1:0] interface_scenario_indicator,
  output logic [1:0] active_scenario,
  output logic secondary_three_wire
);

  pad_pull_if #(.N(N)) pulls ();

  assign pulls.wr_en = pull_en_write;
  assign pulls.wr_dir = pull_dir_write;
  assign pulls.wr_data_en = pull_en_value;
  assign pulls.wr_data_dir = pull_dir_value;

  pad_pull_regs #(.N(N)) u_pull_regs (
    .clock(clock),
    .rst_b(rst_b),
    .pulls(pulls)
  );

  // scenario: override state held apart from the read-only indicator
  scenario_t scen;
  logic three_wire;
  logic [1:0] next_scen_bits;

  assign next_scen_bits = override_write ? override_scenario : scen;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scen <= SCEN_RESET;
      three_wire <= SEC_THREE_WIRE_RESET;
    end else begin
      scen <= (next_scen_bits == 2'h3) ? scen : scenario_t'(next_scen_bits);
      three_wire <= override_write ? override_three_wire : three_wire;
    end
  end

  // role decode
  wire stab = (scen == SCEN_STAB_SPI);
  wire i2cm = (scen == SCEN_I2C_MASTER);
  wire sec_enabled = stab | i2cm;
  wire host_is_spi4 = (host_protocol == HOST_SPI4);
  wire host_is_spi3 = (host_protocol == HOST_SPI3);
  wire host_is_bus = (host_protocol == HOST_I2C) || (host_protocol == HOST_I3C);
  wire irq2_is_out = (second_irq_role == IRQ2_OUT);

  // next pad values; each drives only when its role is an output
  wire next_hso = host_spi_out_data;
  wire next_hso_oe = host_is_spi4 & host_spi_out_en;
  wire next_hbd = host_is_spi3 ? host_three_wire_out : 1'b0;
  wire next_hbd_oe = host_is_spi3 ? host_three_wire_oe : (host_is_bus & host_sda_low);
  wire next_sd = (stab & three_wire) ? secondary_three_wire_out : 1'b0;
  wire next_sd_oe = stab ? (three_wire & secondary_three_wire_oe) : (i2cm & i2c_master_data_low);
  wire next_sc_oe = i2cm & i2c_master_clock_low;
  wire next_sso_oe = stab & ~three_wire & secondary_spi_out_en;

  // interrupt routing
  wire irq1_level = irq_combined ? (host_irq1 | host_irq2 | secondary_irq) : host_irq1;
  wire irq2_src = sec_enabled ? secondary_irq : host_irq2;
  wire irq2_level = irq_combined ? 1'b0 : irq2_src;
  wire next_irq1_oe = first_irq_open_drain ? irq1_level : 1'b1;
  wire next_irq1 = first_irq_open_drain ? 1'b0 : irq1_level;
  wire next_irq2_oe = irq2_is_out & (second_irq_open_drain ? irq2_level : 1'b1);
  wire next_irq2 = second_irq_open_drain ? 1'b0 : irq2_level;

  // host data-out pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_serial_out <= 1'b0;
      host_serial_out_oe <= 1'b0;
    end else begin
      host_serial_out <= next_hso;
      host_serial_out_oe <= next_hso_oe;
    end
  end

  // host data pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_bus_data_out <= 1'b0;
      host_bus_data_oe <= 1'b0;
    end else begin
      host_bus_data_out <= next_hbd;
      host_bus_data_oe <= next_hbd_oe;
    end
  end

  // secondary data pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      secondary_data_out <= 1'b0;
      secondary_data_oe <= 1'b0;
    end else begin
      secondary_data_out <= next_sd;
      secondary_data_oe <= next_sd_oe;
    end
  end

  // secondary clock pad; the master clock only ever pulls low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      secondary_clock_out <= 1'b0;
      secondary_clock_oe <= 1'b0;
    end else begin
      secondary_clock_out <= 1'b0;
      secondary_clock_oe <= next_sc_oe;
    end
  end

  // secondary data-out pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      secondary_serial_out <= 1'b0;
      secondary_serial_out_oe <= 1'b0;
    end else begin
      secondary_serial_out <= stab ? secondary_spi_out_data : 1'b0;
      secondary_serial_out_oe <= next_sso_oe;
    end
  end

  // first interrupt pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      first_irq_out <= 1'b0;
      first_irq_oe <= 1'b0;
    end else begin
      first_irq_out <= next_irq1;
      first_irq_oe <= next_irq1_oe;
    end
  end

  // second interrupt pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      second_irq_out <= 1'b0;
      second_irq_oe <= 1'b0;
    end else begin
      second_irq_out <= next_irq2;
      second_irq_oe <= next_irq2_oe;
    end
  end

  // address strap: upper bits fixed, low bit from the host data-out pad
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slave_address <= 7'h00;
    end else begin
      slave_address <= {SLAVE_ADDR_UPPER, host_serial_out_in};
    end
  end

  // host pads toward the core
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_clock_to_core <= 1'b0;
      host_data_to_core <= 1'b0;
      host_select_to_core <= 1'b1;
    end else begin
      host_clock_to_core <= host_bus_clock_in;
      host_data_to_core <= host_bus_data_in;
      host_select_to_core <= host_chip_select_in;
    end
  end

  // secondary pads toward the core; idle levels while the port is off
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      secondary_data_to_core <= 1'b0;
      secondary_clock_to_core <= 1'b0;
      secondary_select_to_core <= 1'b1;
    end else begin
      secondary_data_to_core <= sec_enabled ? secondary_data_in : 1'b0;
      secondary_clock_to_core <= sec_enabled ? secondary_clock_in : 1'b0;
      secondary_select_to_core <= stab ? secondary_chip_select_in : 1'b1;
    end
  end

  // second interrupt pad used as an input
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_sync_in <= 1'b0;
      external_clock_in <= 1'b0;
    end else begin
      frame_sync_in <= (second_irq_role == IRQ2_FRAME_SYNC_IN) & second_irq_pad_in;
      external_clock_in <= (second_irq_role == IRQ2_EXTERNAL_CLOCK_IN) & second_irq_pad_in;
    end
  end

  // pull bit mirror
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pull_en <= PULL_EN_RESET;
      pull_dir <= PULL_DIR_RESET;
    end else begin
      pull_en <= pulls.pull_en;
      pull_dir <= pulls.pull_dir;
    end
  end

  // status; indicator shows the reset scenario and never the override
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      interface_scenario_indicator <= SCEN_RESET;
      active_scenario <= SCEN_RESET;
      secondary_three_wire <= SEC_THREE_WIRE_RESET;
    end else begin
      interface_scenario_indicator <= SCEN_RESET;
      active_scenario <= scen;
      secondary_three_wire <= three_wire;
    end
  end

endmodule : pad_function_and_pull_control

/* verif/pad_mux_chk.sv */
// checker: port-level assertions for the pad function and pull block
module pad_mux_chk
  import pad_mux_pkg::*;
#(
  parameter int unsigned N = PAD_COUNT
) (
  // watched ports
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [N-1:0] pull_en_write,
  input wire logic [N-1:0] pull_dir_write,
  input wire logic [N-1:0] pull_en_value,
  input wire logic [N-1:0] pull_dir_value,
  input wire logic [N-1:0] pull_en,
  input wire logic [N-1:0] pull_dir,
  input wire logic [1:0] host_protocol,
  input wire logic host_spi_out_en,
  input wire logic host_serial_out_in,
  input wire logic host_serial_out_oe,
  input wire logic secondary_serial_out_oe,
  input wire logic secondary_data_oe,
  input wire logic secondary_clock_oe,
  input wire logic [1:0] second_irq_role,
  input wire logic second_irq_oe,
  input wire logic [6:0] slave_address,
  input wire logic [1:0] interface_scenario_indicator,
  input wire logic [1:0] active_scenario
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_en_wr; ((pull_en ^ $past(pull_en_value, 2)) & $past(pull_en_write, 2) & ~$past(pull_en_write)) == '0; endproperty
  a_en_wr: assert property (p_en_wr) else $error("pull enable write lost");
  property p_dir_wr; ((pull_dir ^ $past(pull_dir_value, 2)) & $past(pull_dir_write, 2) & ~$past(pull_dir_write)) == '0; endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("pull direction write lost");
  property p_en_hold; $changed(pull_en) |-> $past(pull_en_write, 2) != '0; endproperty
  a_en_hold: assert property (p_en_hold) else $error("pull enable changed unasked");
  property p_addr; $past(rst_b) |-> slave_address == {SLAVE_ADDR_UPPER, $past(host_serial_out_in)}; endproperty
  a_addr: assert property (p_addr) else $error("slave address wrong");
  property p_host_oe; $past(rst_b) && host_serial_out_oe |-> $past(host_protocol) == HOST_SPI4 && $past(host_spi_out_en); endproperty
  a_host_oe: assert property (p_host_oe) else $error("host data out driven");
  property p_single; active_scenario == SCEN_SINGLE && $past(active_scenario) == SCEN_SINGLE
    |-> !$past(secondary_clock_oe) && !$past(secondary_data_oe) && !$past(secondary_serial_out_oe); endproperty
  a_single: assert property (p_single) else $error("secondary pad driven in single mode");
  property p_ind; interface_scenario_indicator == SCEN_RESET; endproperty
  a_ind: assert property (p_ind) else $error("scenario indicator moved");
  property p_irq2; $past(rst_b) && $past(second_irq_role) != IRQ2_OUT |-> !second_irq_oe; endproperty
  a_irq2: assert property (p_irq2) else $error("second irq pad driven as input");
endmodule : pad_mux_chk
bind pad_function_and_pull_control pad_mux_chk #(.N(N)) u_chk (.*);

/* verif/pad_host_model.sv */
// partner: host-side pad levels, address strap and frame sync source
module pad_host_model (
  // clock and strap
  input wire logic clock,
  input wire logic strap,
  // secondary data pad as driven by the device
  input wire logic sec_oe,
  input wire logic sec_out,
  // pad levels seen by the device
  output logic addr_pin,
  output logic sync_pin,
  output logic data_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase = 2'h0;
  assign addr_pin = strap;
  // released line floats to the external pull-up
  assign data_pin = sec_oe ? sec_out : 1'b1;
  assign sync_pin = phase[1];
  always @(posedge clock) phase <= phase + 2'h1;
endmodule : pad_host_model

/* verif/testbench.sv */
// testbench: directed scenarios for the pad function and pull block
module testbench import pad_mux_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_b, override_write, override_three_wire, first_irq_open_drain, second_irq_open_drain, irq_combined;
  logic [9:0] pull_en_write, pull_dir_write, pull_en_value, pull_dir_value, pull_en, pull_dir;
  logic [1:0] override_scenario, host_protocol, second_irq_role, interface_scenario_indicator, active_scenario;
  logic host_spi_out_data, host_spi_out_en, host_sda_low, host_three_wire_out, host_three_wire_oe, strap;
  logic secondary_spi_out_data, secondary_spi_out_en, secondary_three_wire_out, secondary_three_wire_oe;
  logic i2c_master_data_low, i2c_master_clock_low, host_irq1, host_irq2, secondary_irq, secondary_three_wire;
  logic host_serial_out_in, host_bus_clock_in, host_bus_data_in, host_chip_select_in, secondary_data_in;
  logic secondary_clock_in, secondary_chip_select_in, second_irq_pad_in, frame_sync_in, external_clock_in;
  logic host_serial_out, host_serial_out_oe, host_bus_data_out, host_bus_data_oe, secondary_data_out;
  logic secondary_data_oe, secondary_clock_out, secondary_clock_oe, secondary_serial_out, secondary_serial_out_oe;
  logic first_irq_out, first_irq_oe, second_irq_out, second_irq_oe, host_clock_to_core, host_data_to_core;
  logic host_select_to_core, secondary_data_to_core, secondary_clock_to_core, secondary_select_to_core;
  logic [6:0] slave_address;
  logic exp;
  int error_cnt = 0;
  int samples_checked = 0;
  pad_function_and_pull_control #(.N(10)) u_dut (.*);
  pad_host_model u_host (.clock(clock), .strap(strap), .sec_oe(secondary_data_oe), .sec_out(secondary_data_out),
    .addr_pin(host_serial_out_in), .sync_pin(second_irq_pad_in), .data_pin(secondary_data_in));
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic write_pull(input logic [9:0] mask, input logic [9:0] en, input logic [9:0] dir);
    pull_en_write = mask;
    pull_dir_write = mask;
    pull_en_value = en;
    pull_dir_value = dir;
    step(1);
    pull_en_write = '0;
    pull_dir_write = '0;
    step(2);
  endtask : write_pull
  task automatic t_reset();
    check(pull_en, 10'(~(10'h1 << PAD_FIRST_IRQ)));
    check(pull_dir, 10'h3ff);
    check(interface_scenario_indicator, 2'h1);
    check(active_scenario, 2'h1);
    check(secondary_three_wire, 1'b1);
  endtask : t_reset
  task automatic t_pull();
    write_pull(10'h3ff, 10'h000, 10'h000);
    check(pull_en, 10'h000);
    check(pull_dir, 10'h000);
    for (int k = 0; k < 10; k++) begin
      write_pull(10'h1 << k, 10'h3ff, 10'h155);
      check(pull_en, (32'h2 << k) - 32'h1);
    end
    check(pull_dir, 10'h155);
  endtask : t_pull
  task automatic t_host();
    {host_spi_out_en, host_sda_low, host_spi_out_data, host_three_wire_out, host_three_wire_oe} = 5'h1f;
    {host_bus_clock_in, host_bus_data_in, host_chip_select_in} = 3'h6;
    for (int a = 0; a < 2; a++) begin
      strap = a[0];
      step(2);
      check(slave_address, 7'h68 | a);
    end
    for (int p = 0; p < 4; p++) begin
      host_protocol = p[1:0];
      step(2);
      check(host_serial_out_oe, p == 3);
      check(host_serial_out, 1'b1);
      check(host_bus_data_oe, p != 3);
      check(host_bus_data_out, p == 2);
    end
    check({host_clock_to_core, host_data_to_core, host_select_to_core}, 3'h6);
  endtask : t_host
  task automatic t_scen();
    int e;
    {secondary_spi_out_en, i2c_master_clock_low, i2c_master_data_low, secondary_irq} = 4'hf;
    {secondary_spi_out_data, secondary_clock_in, secondary_chip_select_in} = 3'h6;
    second_irq_open_drain = 1'b1;
    for (int s = 0; s < 4; s++) begin
      e = (s == 3) ? 2 : s;
      override_scenario = s[1:0];
      override_write = 1'b1;
      step(1);
      override_write = 1'b0;
      step(3);
      check(active_scenario, e);
      check(secondary_serial_out_oe, e == 1);
      check(secondary_serial_out, e == 1);
      check(secondary_clock_oe, e == 2);
      check(secondary_clock_to_core, e != 0);
      check(secondary_data_oe, e == 2);
      check(secondary_data_to_core, e == 1);
      check(secondary_select_to_core, e != 1);
      check(second_irq_oe, e != 0);
    end
    check(secondary_three_wire, 1'b0);
    {override_three_wire, secondary_three_wire_out, secondary_three_wire_oe} = 3'h7;
    override_scenario = 2'h1;
    override_write = 1'b1;
    step(1);
    override_write = 1'b0;
    step(3);
    check({secondary_data_oe, secondary_data_out, secondary_serial_out_oe}, 3'h6);
    check(secondary_three_wire, 1'b1);
  endtask : t_scen
  task automatic t_irq();
    {secondary_irq, host_irq2, irq_combined, first_irq_open_drain} = 4'h7;
    step(2);
    check(first_irq_oe, 1'b1);
    check(second_irq_oe, 1'b0);
    {irq_combined, first_irq_open_drain, host_irq1} = 3'h1;
    step(2);
    check(first_irq_out, 1'b1);
    {second_irq_open_drain, secondary_irq, host_irq2} = 3'h2;
    step(2);
    check({second_irq_oe, second_irq_out}, 2'h3);
    {secondary_irq, host_irq2} = 2'h1;
    step(2);
    check(second_irq_out, 1'b0);
    for (int r = 1; r < 3; r++) begin
      second_irq_role = r[1:0];
      step(2);
      for (int i = 0; i < 4; i++) begin
        exp = second_irq_pad_in;
        step(1);
        check(r == 1 ? frame_sync_in : external_clock_in, exp);
        check(r == 1 ? external_clock_in : frame_sync_in, 1'b0);
      end
    end
  endtask : t_irq
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
  initial begin
    {pull_en_write, pull_dir_write, pull_en_value, pull_dir_value} = '0;
    {override_write, override_three_wire, override_scenario, host_protocol, second_irq_role, strap} = '0;
    {first_irq_open_drain, second_irq_open_drain, irq_combined, host_spi_out_data, host_spi_out_en} = '0;
    {host_sda_low, host_three_wire_out, host_three_wire_oe, secondary_spi_out_data, secondary_spi_out_en} = '0;
    {secondary_three_wire_out, secondary_three_wire_oe, i2c_master_data_low, i2c_master_clock_low} = '0;
    {host_irq1, host_irq2, secondary_irq, host_bus_clock_in, host_bus_data_in, host_chip_select_in} = '0;
    {secondary_clock_in, secondary_chip_select_in} = '0;
    rst_b = 1'b0;
    step(12);
    rst_b = 1'b1;
    step(1);
    t_reset();
    t_pull();
    t_host();
    t_scen();
    t_irq();
    conclude();
  end
endmodule : testbench
